//--- rtl/gated_timer_pkg.sv
// Purpose: Shared constants and types for the gated 16-bit timer/counter.
// Assumes: Avalon-MM register access with 32-bit data, one register per word.
// Notes: Register offsets are byte addresses.
package gated_timer_pkg;
    localparam logic [7:0] CONTROL_OFFSET = 8'h10;
    localparam logic [7:0] COUNT_LOW_OFFSET = 8'h14;
    localparam logic [7:0] COUNT_HIGH_OFFSET = 8'h18;
    localparam logic [7:0] FLAG_OFFSET = 8'h1C;
    localparam logic [7:0] ENABLE_OFFSET = 8'h20;
    localparam logic [7:0] COMPARATOR_CTRL_OFFSET = 8'h24;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int RUN_BIT = 0;
    localparam int CLOCK_SOURCE_BIT = 1;
    localparam int SYNC_DISABLE_BIT = 2;
    localparam int LP_OSC_BIT = 3;
    localparam int PRESCALE_LSB = 4;
    localparam int GATE_ENABLE_BIT = 6;
    localparam int GATE_INVERT_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam int OVERFLOW_IE_BIT = 0;
    localparam int PERIPH_IE_BIT = 1;
    localparam int GLOBAL_IE_BIT = 2;
    localparam int GATE_SOURCE_BIT = 1;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    typedef struct packed {
        logic       gate_invert;
        logic       gate_enable;
        logic [1:0] prescale_select;
        logic       lp_osc_enable;
        logic       ext_sync_disable;
        logic       clock_source_select;
        logic       timer_run;
    } control_s;

    typedef struct packed {
        logic [7:0] address;
        logic       read;
        logic       write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } bus_request_s;
endpackage

//--- rtl/gated_timer.sv
// Purpose: 16-bit timer/counter with prescaler, gate and overflow flag.
// Assumes: Pins are asynchronous to sys_clk and are resynchronised here.
// Notes: Reset models the power-on reset; the count bytes are never reset.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - 16-bit counter, both bytes software accessible.
// - Wraps FFFFh to 0000h with overflow event.
// - Overflow sets flag bit 0.
// - Interrupt needs three enables all set.
// - Flag stays until software writes zero.
// - Timer mode advances per cycle via prescaler.
// - Counter mode counts external or oscillator rising edges.
// - First falling edge required before counting.
// - Bit 1 selects internal or external clock.
// - Bit 2 selects asynchronous counting, which only enables wake; the count edge is resynchronised either way.
// - Bit 0 starts and stops counting.
// - Bits 5:4 divide by 1,2,4,8.
// - Prescaler hidden, cleared on count writes.
// - Gate source pin or comparator two.
// - Gate acts only when bit 6 set.
// - Bit 7 inverts gate for any source.
// - Count only while gate is active.
// - Oscillator clocks counter only on internal oscillator.
// - Asynchronous counting raises wake on overflow if enable bits 0 and 1 are set.
// - Control cleared by power-on reset.
// - Count bytes untouched by reset.
module gated_timer
    import gated_timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_clock_pin,
    input wire logic low_power_oscillator,
    input wire logic gate_pin,
    input wire logic comparator_two_output,
    input wire logic internal_oscillator_no_clkout,
    output logic irq,
    output logic wake
);
    typedef struct packed {
        control_s   ctrl;
        logic [15:0] count;
        logic [2:0] prescale;
        logic       flag;
        logic [2:0] enables;
        logic       gate_source_select;
        logic [1:0] ext_sync;
        logic [1:0] osc_sync;
        logic [1:0] gate_sync;
        logic [1:0] comp_sync;
        logic       clk_prev;
        logic       armed;
        logic       answered;
        logic [31:0] readdata;
        logic       irq;
        logic       wake;
        logic       waitreq;
        logic [1:0] strap_sync;
    } state_s;

    state_s cur;
    state_s next_cur;
    bus_request_s req;
    logic source_level;
    logic gate_level;
    logic gate_open;
    logic tick;
    logic prescale_done;
    logic access;
    logic commit;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_flag;
    logic [15:0] bumped;
    logic overflow;

    function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
        prescale_limit = 3'((4'h1 << sel) - 4'h1);
    endfunction

    always_comb begin
        req = '{address: avs_address, read: avs_read, write: avs_write,
                writedata: avs_writedata, byteenable: avs_byteenable};
        access = (req.read || req.write) && !cur.answered;
        // Writes land at the edge where the master sees waitrequest low, so a held request acts once.
        commit = req.write && cur.answered && req.byteenable[0];
        wr_ctrl = commit && req.address == CONTROL_OFFSET;
        wr_low = commit && req.address == COUNT_LOW_OFFSET;
        wr_high = commit && req.address == COUNT_HIGH_OFFSET;
        wr_flag = commit && req.address == FLAG_OFFSET;
        // Oscillator only usable when the core runs from the internal oscillator without clock out.
        if (cur.ctrl.lp_osc_enable && cur.strap_sync[1]) begin
            source_level = cur.osc_sync[1];
        end else begin
            source_level = cur.ext_sync[1];
        end
        gate_level = cur.gate_source_select ? cur.comp_sync[1] : cur.gate_sync[1];
        // Invert clear means active low, so the open level equals the invert bit.
        gate_open = !cur.ctrl.gate_enable || (gate_level == cur.ctrl.gate_invert);
        // Asynchronous mode also uses the resynchronised edge: sys_clk is the only clock here.
        if (cur.ctrl.clock_source_select) begin
            tick = source_level && !cur.clk_prev && cur.armed;
        end else begin
            tick = 1'b1;
        end
        tick = tick && cur.ctrl.timer_run && gate_open;
        prescale_done = cur.prescale >= prescale_limit(cur.ctrl.prescale_select);
        bumped = 16'(cur.count + 16'h0001);
        overflow = tick && prescale_done && cur.count == COUNT_MAX;

        next_cur = cur;
        next_cur.ext_sync = {cur.ext_sync[0], ext_clock_pin};
        next_cur.osc_sync = {cur.osc_sync[0], low_power_oscillator};
        next_cur.gate_sync = {cur.gate_sync[0], gate_pin};
        next_cur.comp_sync = {cur.comp_sync[0], comparator_two_output};
        next_cur.strap_sync = {cur.strap_sync[0], internal_oscillator_no_clkout};
        next_cur.clk_prev = source_level;
        if (!cur.ctrl.clock_source_select) begin
            next_cur.armed = 1'b0;
        end else if (!source_level && cur.clk_prev) begin
            next_cur.armed = 1'b1;
        end
        if (tick) begin
            if (prescale_done) begin
                next_cur.prescale = 3'h0;
                next_cur.count = bumped;
            end else begin
                next_cur.prescale = 3'(cur.prescale + 3'h1);
            end
        end
        if (wr_low) begin
            next_cur.count[7:0] = req.writedata[7:0];
            next_cur.prescale = 3'h0;
        end
        if (wr_high) begin
            next_cur.count[15:8] = req.writedata[7:0];
            next_cur.prescale = 3'h0;
        end
        if (wr_ctrl) begin
            next_cur.ctrl = control_s'(req.writedata[7:0]);
        end
        if (commit && req.address == ENABLE_OFFSET) begin
            next_cur.enables = req.writedata[2:0];
        end
        if (commit && req.address == COMPARATOR_CTRL_OFFSET) begin
            next_cur.gate_source_select = req.writedata[GATE_SOURCE_BIT];
        end
        if (wr_flag) begin
            next_cur.flag = req.writedata[FLAG_BIT];
        end
        if (overflow) begin
            next_cur.flag = 1'b1;
        end
        next_cur.irq = next_cur.flag && &next_cur.enables;
        next_cur.wake = overflow && cur.ctrl.clock_source_select && cur.ctrl.ext_sync_disable
                        && cur.enables[OVERFLOW_IE_BIT] && cur.enables[PERIPH_IE_BIT];
        next_cur.answered = access;
        next_cur.waitreq = !access;
        next_cur.readdata = 32'h0;
        if (access && req.read) begin
            case (req.address)
                CONTROL_OFFSET: next_cur.readdata = {24'h0, cur.ctrl};
                COUNT_LOW_OFFSET: next_cur.readdata = {24'h0, cur.count[7:0]};
                COUNT_HIGH_OFFSET: next_cur.readdata = {24'h0, cur.count[15:8]};
                FLAG_OFFSET: next_cur.readdata = {31'h0, cur.flag};
                ENABLE_OFFSET: next_cur.readdata = {29'h0, cur.enables};
                COMPARATOR_CTRL_OFFSET: next_cur.readdata = {30'h0, cur.gate_source_select, 1'b0};
                default: next_cur.readdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur <= next_cur;
            cur.ctrl <= control_s'(CONTROL_RESET);
            cur.prescale <= 3'h0;
            cur.flag <= 1'b0;
            cur.enables <= 3'h0;
            cur.gate_source_select <= 1'b0;
            cur.armed <= 1'b0;
            cur.answered <= 1'b0;
            cur.waitreq <= 1'b1;
            cur.readdata <= 32'h0;
            cur.irq <= 1'b0;
            cur.wake <= 1'b0;
            cur.count <= cur.count;
        end else begin
            cur <= next_cur;
        end
    end

    // Waitrequest idles high and drops for one cycle per access, so it too comes from a flop.
    assign avs_waitrequest = cur.waitreq;
    assign avs_readdata = cur.readdata;
    assign irq = cur.irq;
    assign wake = cur.wake;
endmodule // gated_timer

`default_nettype wire

//--- testbench/gated_timer_sva.sv
// Purpose: Port-level checks for the gated timer.
// Assumes: One wait cycle per bus access.
// Notes: Bound into every instance of the design.
`timescale 1ns/1ns
`default_nettype none
module gated_timer_sva
    import gated_timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic wake
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire rd_done = avs_read && !avs_waitrequest;
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait cycle");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    ctrl_byte_a: assert property (rd_done && avs_address == CONTROL_OFFSET |-> avs_readdata[31:8] == 24'h0)
        else $error("control upper bits set");
    flag_bit_a: assert property (rd_done && avs_address == FLAG_OFFSET |-> avs_readdata[31:1] == 31'h0)
        else $error("flag upper bits set");
    unmapped_zero_a: assert property (rd_done && avs_address == 8'h00 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    flag_sticky_a: assert property (irq && !avs_write && !$past(avs_write) |=> irq)
        else $error("irq dropped by itself");
    wake_pulse_a: assert property (wake |=> !wake) else $error("wake longer than one cycle");
    reset_quiet_a: assert property ($rose(reset_n) |-> !irq && !wake) else $error("output set after reset");
    rdata_hold_a: assert property (!avs_read && !avs_write |=> $stable(avs_readdata)) else $error("readdata moved");
    cover property (wake);
    cover property ($fell(irq));
    cover property (rd_done && avs_address == FLAG_OFFSET);
endmodule // gated_timer_sva
bind gated_timer gated_timer_sva u_sva (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .irq, .wake);
`default_nettype wire

//--- testbench/pin_source_model.sv
// Purpose: Pin-side model of external clock, gate pin and comparator.
// Assumes: The external clock runs free at a sixteenth of sys_clk.
// Notes: Gate levels change only when the bench asks.
`timescale 1ns/1ns
`default_nettype none
module pin_source_model (
    input wire logic sys_clk,
    input wire logic [1:0] gate_cmd,
    output logic ext_clock_pin,
    output logic gate_pin,
    output logic comparator_two_output,
    output logic low_power_oscillator
);
    logic [3:0] phase = 4'h0;
    always @(posedge sys_clk) phase <= phase + 4'h1;
    assign ext_clock_pin = phase[3];
    assign low_power_oscillator = phase[2];
    assign gate_pin = gate_cmd[0];
    assign comparator_two_output = gate_cmd[1];
endmodule // pin_source_model
`default_nettype wire

//--- testbench/gated_16bit_timer_counter_tb.sv
// Purpose: Self-checking bench for the gated 16-bit timer/counter.
// Assumes: Pin synchronisers add a few cycles, so counts get a tolerance.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
`define check_eq(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module gated_16bit_timer_counter_tb;
    import gated_timer_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, v;
    logic [1:0] gate_cmd = 2'h0;
    logic osc_ok = 1'b1;
    logic avs_waitrequest, irq, wake, ext_clk, gate_pin, comp_out, lp_osc;
    int error_cnt = 0, checks_done = 0, cycles = 0, n;
    gated_timer dut (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ext_clock_pin(ext_clk),
        .low_power_oscillator(lp_osc), .gate_pin, .comparator_two_output(comp_out),
        .internal_oscillator_no_clkout(osc_ok), .irq, .wake);
    pin_source_model far (.sys_clk, .gate_cmd, .ext_clock_pin(ext_clk), .gate_pin,
        .comparator_two_output(comp_out), .low_power_oscillator(lp_osc));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic near(input logic [7:0] got, input int exp);
        return (int'(got) >= exp - 2) && (int'(got) <= exp + 2);
    endfunction
    // Gate is active low unless inverted, from pin or comparator.
    function automatic logic gate_on(input logic inv, input logic src, input logic [1:0] lv);
        return inv ? (src ? lv[1] : lv[0]) : !(src ? lv[1] : lv[0]);
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(59));
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        bus(0, CONTROL_OFFSET, 0);
        `check_eq("control reset", 32'h0, rd)
        bus(0, 8'h00, 0);
        `check_eq("unmapped", 32'h0, rd)
        v = $urandom;
        bus(1, CONTROL_OFFSET, v);
        bus(0, CONTROL_OFFSET, 0);
        `check_eq("control", {24'h0, v[7:0]}, rd)
        bus(1, CONTROL_OFFSET, 0);
        bus(1, COUNT_HIGH_OFFSET, {24'h0, v[23:16]});
        bus(0, COUNT_HIGH_OFFSET, 0);
        `check_eq("high byte", {24'h0, v[23:16]}, rd)
        $display("test registers done");
        // Odd prescale codes also set the sync bit, which must not matter here.
        for (int ps = 0; ps < 4; ps++) begin
            bus(1, COUNT_LOW_OFFSET, 0);
            bus(1, CONTROL_OFFSET, 32'h1 | (ps << 4) | ((ps << 2) & 4));
            repeat (64) @(posedge sys_clk);
            bus(1, CONTROL_OFFSET, 0);
            bus(0, COUNT_LOW_OFFSET, 0);
            `check_eq("prescaled count", 1'b1, near(rd[7:0], 67 >> ps))
        end
        $display("test prescale done");
        // The oscillator runs twice as fast as the external clock, so the source shows in the count.
        for (int k = 0; k < 2; k++) begin
            osc_ok <= !k[0];
            bus(1, COUNT_LOW_OFFSET, 0);
            bus(1, CONTROL_OFFSET, 32'h0B);
            repeat (64) @(posedge sys_clk);
            bus(1, CONTROL_OFFSET, 0);
            bus(0, COUNT_LOW_OFFSET, 0);
            `check_eq("oscillator count", 1'b1, near(rd[7:0], k ? 4 : 8))
        end
        $display("test oscillator done");
        bus(1, FLAG_OFFSET, 0);
        bus(1, COUNT_LOW_OFFSET, 32'hFD);
        bus(1, COUNT_HIGH_OFFSET, 32'hFF);
        bus(1, ENABLE_OFFSET, 32'h7);
        bus(1, CONTROL_OFFSET, 32'h7);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        `check_eq("irq on wrap", 1'b1, irq)
        `check_eq("wake on wrap", 1'b1, wake)
        bus(1, CONTROL_OFFSET, 0);
        bus(0, COUNT_HIGH_OFFSET, 0);
        `check_eq("high after wrap", 32'h0, rd)
        for (int m = 0; m < 8; m++) begin
            bus(1, ENABLE_OFFSET, m);
            @(negedge sys_clk);
            `check_eq("irq mask", m == 7, irq)
        end
        bus(0, FLAG_OFFSET, 0);
        `check_eq("flag held", 32'h1, rd)
        bus(1, FLAG_OFFSET, 0);
        @(negedge sys_clk);
        `check_eq("irq cleared", 1'b0, irq)
        $display("test overflow done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            gate_cmd <= v[1:0];
            bus(1, COMPARATOR_CTRL_OFFSET, {30'h0, i[1], 1'b0});
            bus(1, COUNT_LOW_OFFSET, 0);
            bus(1, CONTROL_OFFSET, {24'h0, i[2], 7'h43});
            repeat (160) @(posedge sys_clk);
            bus(1, CONTROL_OFFSET, 0);
            bus(0, COUNT_LOW_OFFSET, 0);
            `check_eq("gated count", gate_on(i[2], i[1], v[1:0]), rd[7:0] != 8'h00)
        end
        $display("test gate done");
        wrap_up();
    end
endmodule // gated_16bit_timer_counter_tb
`default_nettype wire
